// ===== verilog/scfb_consts.vh
/*
   Constants for the circular-buffer serial port: register offsets, field
   positions, reset values and timing counts.
   Assumes it is included by bare name from the design files.
*/
`ifndef SCFB_CONSTS_VH
`define SCFB_CONSTS_VH
`define SCFB_ADDR_DATA      4'h0
`define SCFB_ADDR_TCON      4'h1
`define SCFB_ADDR_RCON      4'h2
`define SCFB_ADDR_START     4'h3
`define SCFB_ADDR_END       4'h4
`define SCFB_ADDR_TTHR      4'h5
`define SCFB_ADDR_RTHR      4'h6
`define SCFB_ADDR_PSTAT     4'h7
`define SCFB_ADDR_CTRL      4'h8
`define SCFB_FLUSH_BIT      7
`define SCFB_TXF_BIT        3
`define SCFB_RXF_BIT        2
`define SCFB_CNT_MASK       8'h7F
`define SCFB_CTRL_EN_BIT    0
`define SCFB_RST_BYTE       8'h00
`define SCFB_VECTOR         8'h33
`define SCFB_FIFO_DEPTH     32
`define SCFB_FIFO_AW        5
`define SCFB_CLK_DIV        4'h7
`endif

// ===== verilog/scfb_fifo.v
/*
   Parameterised valid/ready FIFO for the serial data path.
   Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
module scfb_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             SYS_CLK,
   input  wire             RST,
   input  wire [WIDTH-1:0] IN_DATA,
   input  wire             IN_VALID,
   output wire             IN_READY,
   output wire [WIDTH-1:0] OUT_DATA,
   output wire             OUT_VALID,
   input  wire             OUT_READY
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words.
   reg [AW:0]      wr_ff;           // Write pointer with wrap bit.
   reg [AW:0]      rd_ff;           // Read pointer with wrap bit.
   wire            full;            // All words occupied.
   wire            empty;           // No words occupied.

   // Extra wrap bit tells full from empty without a separate counter.
   assign full      = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
   assign empty     = (wr_ff == rd_ff);
   assign IN_READY  = ~full;
   assign OUT_VALID = ~empty;
   assign OUT_DATA  = mem[rd_ff[AW-1:0]];

   // Store a word when both sides of the fill handshake agree.
   always @(posedge SYS_CLK) begin
      if (IN_VALID && !full) begin
         mem[wr_ff[AW-1:0]] <= IN_DATA;
      end
   end

   // Pointers advance on accepted handshakes only.
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         wr_ff <= {(AW+1){1'b0}};
         rd_ff <= {(AW+1){1'b0}};
      end else begin
         if (IN_VALID && !full) begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (OUT_READY && !empty) begin
            rd_ff <= rd_ff + 1'b1;
         end
      end
   end
endmodule

// ===== verilog/scfb_top.v
/*
   Circular-buffer serial port master: transmit and receive queues live in
   one small data memory between a start and an end boundary.
   Assumes a byte-wide register port on SYS_CLK and an external slave that
   answers on MISO; SCK is made here by division and sampled back.
   A transmit flush also drops bytes already staged in the FIFO; a byte that
   is on the wire at that moment still finishes, but it no longer counts.
*/
// Overview of operation
// R1: Transmit flush empties queue, zeroes count.
// R2: Receive flush drops unread bytes, resets count.
// R3: Start write sets lower bound and end pointer.
// R4: End write sets upper bound, pointer reverts.
// R5: Equal pointers mean an empty buffer.
// R6: Data write stores byte, advances pointer, counts.
// R7: Transmit count drops per byte shifted out.
// R8: Transmit flag while count below threshold.
// R9: Receive flag when count exceeds threshold.
// R10: Either flag raises shared interrupt, vector 0x33.
// R11: Transmit flag is status bit 0x08.
// R12: Receive flag is status bit 0x04.
// R13: Receive control: flush top bit, count low.
// R14: Data read gives oldest byte, advances.
// R15: Received bytes stored and counted.
// R16: Boundaries stay fixed during traffic.
// R17: Thresholds programmable independently.
// R18: Pointers wrap from upper to lower bound.
// R19: Flush leaves bounds and thresholds alone.
`timescale 1ns/10ps
`include "scfb_consts.vh"
module scfb_top (
   input  wire       SYS_CLK,
   input  wire       RST,
   input  wire [3:0] REG_ADDR,
   input  wire [7:0] REG_WDATA,
   input  wire       REG_WR,
   input  wire       REG_RD,
   output reg  [7:0] REG_RDATA,
   output reg        AUX_IRQ,
   output reg  [7:0] IRQ_VECTOR,
   output reg        SCK,
   output reg        MOSI,
   input  wire       MISO
);
   // Buffer memory and pointers.
   reg  [7:0] mem [0:255];       // Circular buffer storage.
   reg  [7:0] lo_ff;             // Lower boundary.
   reg  [7:0] hi_ff;             // Upper boundary.
   reg  [7:0] tx_wp_ff;          // Transmit write pointer (start pointer reg).
   reg  [7:0] tx_rp_ff;          // Transmit read position.
   reg  [7:0] rx_wp_ff;          // Receive write position.
   reg  [7:0] rx_rp_ff;          // Receive read pointer (end pointer reg).
   reg  [6:0] tx_cnt_ff;         // Bytes waiting to go out.
   reg  [6:0] rx_cnt_ff;         // Bytes waiting to be read.
   reg  [6:0] tx_thr_ff;         // Transmit threshold level.
   reg  [6:0] rx_thr_ff;         // Receive threshold level.
   reg        txf_ff;            // Sticky transmit flag.
   reg        rxf_ff;            // Sticky receive flag.
   reg        en_ff;             // Link enable; gates moves from the buffer into the FIFO.
   reg        rx_pend_ff;        // Received byte waiting for the memory port.
   reg  [5:0] stg_cnt_ff;        // Bytes handed to the FIFO, not yet finished.
   reg  [5:0] drop_cnt_ff;       // Oldest staged bytes made stale by a flush.
   // Shifter state.
   reg  [3:0] div_ff;            // Clock divider.
   reg  [7:0] sh_ff;             // Shift register.
   reg  [2:0] bit_ff;            // Bit counter.
   reg  [1:0] st_ff;             // Shifter state.
   reg  [2:0] miso_sy_ff;        // MISO synchroniser.
   reg  [2:0] sck_sy_ff;         // SCK sample-back synchroniser.
   reg        miso_ff;           // Filtered MISO level.
   reg        sck_in_ff;         // Filtered SCK level.
   reg        sck_prev_ff;       // Previous filtered SCK.
   reg        byte_done_ff;      // One byte finished shifting.
   reg  [7:0] rx_byte_ff;        // Byte just received.
   // FIFO handshake wires.
   wire [7:0] f_out;             // FIFO head byte.
   wire       f_valid;           // FIFO holds a byte.
   wire       f_in_ready;        // FIFO can accept.
   reg        f_pop;             // Shifter takes a byte.
   wire       f_push;            // Buffer hands a byte to FIFO.
   wire       wr_data;           // Data register write.
   wire       rd_data;           // Data register read.
   wire       sck_rise;          // Sampled SCK rising edge.
   wire       sck_fall;          // Sampled SCK falling edge.
   reg  [7:0] nxt_rdata;         // Read mux result.
   wire       tx_flush;          // Transmit flush write.
   wire [5:0] stg_nxt;           // Staged count after this cycle.
   wire       stale_head;        // FIFO head belongs to a flushed batch.
   wire       skip;              // Idle shifter discards a stale head.
   wire       done_stale;        // Finished byte was a flushed one.
   wire       rx_store;          // A received byte wants the memory port.
   wire       rx_commit;         // The received byte is written this cycle.

   localparam ST_IDLE = 2'b00;   // Waiting for a byte.
   localparam ST_SHFT = 2'b01;   // Shifting bits.
   localparam ST_DONE = 2'b10;   // Byte complete.

   // Advance a pointer inside the boundaries, wrapping past the top.
   function [7:0] nxt_ptr;
      input [7:0] p;
      input [7:0] lo;
      input [7:0] hi;
      begin
         nxt_ptr = (p >= hi) ? lo : p + 8'h01; // [R18]
      end
   endfunction

   // One-bit flag update where a set beats a clear.
   function set_clr;
      input cur;
      input set;
      input clr;
      begin
         set_clr = set | (cur & ~clr);
      end
   endfunction

   assign wr_data  = REG_WR && (REG_ADDR == `SCFB_ADDR_DATA);
   assign rd_data  = REG_RD && (REG_ADDR == `SCFB_ADDR_DATA);
   // The buffer feeds the FIFO while the link is enabled, the FIFO has room and bytes are queued and not yet moved.
   assign f_push   = (tx_rp_ff != tx_wp_ff) && f_in_ready && en_ff; // [R5]
   assign sck_rise = sck_in_ff && !sck_prev_ff;
   assign sck_fall = !sck_in_ff && sck_prev_ff;
   assign tx_flush = REG_WR && (REG_ADDR == `SCFB_ADDR_TCON) && REG_WDATA[`SCFB_FLUSH_BIT];
   // A processor write owns the memory port; a received byte waits a cycle.
   assign rx_store   = byte_done_ff | rx_pend_ff; // [R15]
   assign rx_commit  = rx_store && !wr_data;
   // Stale bytes are always the oldest, so the head is stale while more
   // flushed bytes remain than the one finishing in this cycle.
   assign stale_head = (drop_cnt_ff > {5'h00, byte_done_ff});
   assign skip       = (st_ff == ST_IDLE) && f_valid && !f_pop && stale_head; // [R1]
   assign done_stale = byte_done_ff && (drop_cnt_ff != 6'h00);
   assign stg_nxt    = stg_cnt_ff + {5'h00, f_push} - {5'h00, byte_done_ff}
                       - {5'h00, skip};

   scfb_fifo #(
      .WIDTH (8),
      .DEPTH (`SCFB_FIFO_DEPTH),
      .AW    (`SCFB_FIFO_AW)
   ) u_fifo (
      .SYS_CLK   (SYS_CLK),
      .RST       (RST),
      .IN_DATA   (mem[tx_rp_ff]),
      .IN_VALID  (f_push),
      .IN_READY  (f_in_ready),
      .OUT_DATA  (f_out),
      .OUT_VALID (f_valid),
      .OUT_READY (f_pop)
   );

   // Buffer memory writes: processor transmit bytes and received bytes.
   // Both share one array, so a received byte lands at the receive pointer.
   always @(posedge SYS_CLK) begin
      if (wr_data) begin
         mem[tx_wp_ff] <= REG_WDATA; // [R6]
      end else if (rx_store) begin
         mem[rx_wp_ff] <= rx_byte_ff; // [R15]
      end
   end

   // Register file, pointers, counters and flags.
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         lo_ff     <= `SCFB_RST_BYTE;
         hi_ff     <= `SCFB_RST_BYTE;
         tx_wp_ff  <= `SCFB_RST_BYTE;
         tx_rp_ff  <= `SCFB_RST_BYTE;
         rx_wp_ff  <= `SCFB_RST_BYTE;
         rx_rp_ff  <= `SCFB_RST_BYTE;
         tx_cnt_ff <= 7'h00;
         rx_cnt_ff <= 7'h00;
         tx_thr_ff <= 7'h00;
         rx_thr_ff <= 7'h00;
         txf_ff    <= 1'b0;
         rxf_ff    <= 1'b0;
         en_ff     <= 1'b0;
         rx_pend_ff  <= 1'b0;
         stg_cnt_ff  <= 6'h00;
         drop_cnt_ff <= 6'h00;
      end else begin
         // Transmit side: write, move to FIFO, shifted out, flush.
         if (tx_flush) begin
            // Keep the pointers equal even if a byte is staged in this cycle.
            tx_wp_ff  <= f_push ? nxt_ptr(tx_rp_ff, lo_ff, hi_ff) : tx_rp_ff; // [R1]
            tx_cnt_ff <= 7'h00;    // [R1] [R19]
         end else begin
            if (wr_data) begin
               tx_wp_ff <= nxt_ptr(tx_wp_ff, lo_ff, hi_ff); // [R6]
            end
            // Count both ways at once so a write and a completion cancel.
            // A flushed byte that finishes on the wire no longer counts.
            tx_cnt_ff <= tx_cnt_ff + {6'h00, wr_data}
                         - {6'h00, (byte_done_ff && !done_stale
                                    && tx_cnt_ff != 7'h00)}; // [R7]
         end
         if (f_push) begin
            tx_rp_ff <= nxt_ptr(tx_rp_ff, lo_ff, hi_ff);
         end
         // Every staged byte turns stale at a flush; queued ones are skipped later, one on the wire finishes uncounted.
         stg_cnt_ff <= stg_nxt;
         if (tx_flush) begin
            drop_cnt_ff <= stg_nxt; // [R1]
         end else begin
            drop_cnt_ff <= drop_cnt_ff - {5'h00, done_stale} - {5'h00, skip};
         end
         // Receive side: captured byte, processor read, flush.
         if (REG_WR && REG_ADDR == `SCFB_ADDR_RCON && REG_WDATA[`SCFB_FLUSH_BIT]) begin
            // A byte stored in the flush cycle is dropped with the rest.
            rx_rp_ff  <= rx_commit ? nxt_ptr(rx_wp_ff, lo_ff, hi_ff) : rx_wp_ff; // [R2]
            rx_cnt_ff <= 7'h00;    // [R2] [R19]
         end else begin
            if (rd_data && rx_cnt_ff != 7'h00) begin
               rx_rp_ff <= nxt_ptr(rx_rp_ff, lo_ff, hi_ff); // [R14]
            end
            rx_cnt_ff <= rx_cnt_ff + {6'h00, rx_commit}
                         - {6'h00, (rd_data && rx_cnt_ff != 7'h00)}; // [R15]
         end
         if (rx_commit) begin
            rx_wp_ff <= nxt_ptr(rx_wp_ff, lo_ff, hi_ff); // [R15]
         end
         // Without this wait a data write in the completion cycle loses the byte.
         rx_pend_ff <= rx_store && wr_data; // [R15]
         // Boundary setup; traffic itself never touches lo_ff or hi_ff.
         if (REG_WR && REG_ADDR == `SCFB_ADDR_START) begin
            lo_ff    <= REG_WDATA; // [R3] [R16]
            tx_wp_ff <= REG_WDATA; // [R3]
            tx_rp_ff <= REG_WDATA;
            rx_wp_ff <= REG_WDATA;
            rx_rp_ff <= REG_WDATA; // [R3] [R5]
         end
         if (REG_WR && REG_ADDR == `SCFB_ADDR_END) begin
            hi_ff    <= REG_WDATA; // [R4] [R16]
            rx_rp_ff <= tx_wp_ff;  // [R4]
         end
         if (REG_WR && REG_ADDR == `SCFB_ADDR_TTHR) begin
            tx_thr_ff <= REG_WDATA[6:0]; // [R17]
         end
         if (REG_WR && REG_ADDR == `SCFB_ADDR_RTHR) begin
            rx_thr_ff <= REG_WDATA[6:0]; // [R17]
         end
         if (REG_WR && REG_ADDR == `SCFB_ADDR_CTRL) begin
            en_ff <= REG_WDATA[`SCFB_CTRL_EN_BIT];
         end
         // Sticky flags: software writes a zero to clear, the condition wins.
         txf_ff <= set_clr(txf_ff, tx_cnt_ff < tx_thr_ff,
                     REG_WR && REG_ADDR == `SCFB_ADDR_PSTAT
                     && !REG_WDATA[`SCFB_TXF_BIT]); // [R8] [R11]
         rxf_ff <= set_clr(rxf_ff, rx_cnt_ff > rx_thr_ff,
                     REG_WR && REG_ADDR == `SCFB_ADDR_PSTAT
                     && !REG_WDATA[`SCFB_RXF_BIT]); // [R9] [R12]
      end
   end

   // Read mux; unmapped addresses read as zero.
   always @* begin
      nxt_rdata = 8'h00;
      case (REG_ADDR)
         `SCFB_ADDR_DATA:  nxt_rdata = mem[rx_rp_ff]; // [R14]
         `SCFB_ADDR_TCON:  nxt_rdata = {1'b0, tx_cnt_ff};
         `SCFB_ADDR_RCON:  nxt_rdata = {1'b0, rx_cnt_ff} & `SCFB_CNT_MASK; // [R13]
         `SCFB_ADDR_START: nxt_rdata = tx_wp_ff;
         `SCFB_ADDR_END:   nxt_rdata = rx_rp_ff;
         `SCFB_ADDR_TTHR:  nxt_rdata = {1'b0, tx_thr_ff};
         `SCFB_ADDR_RTHR:  nxt_rdata = {1'b0, rx_thr_ff};
         `SCFB_ADDR_PSTAT: nxt_rdata = {4'h0, txf_ff, rxf_ff, 2'b00}; // [R11] [R12]
         `SCFB_ADDR_CTRL:  nxt_rdata = {7'h00, en_ff};
         default:          nxt_rdata = 8'h00;
      endcase
   end

   // Registered read data and interrupt outputs.
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         REG_RDATA  <= 8'h00;
         AUX_IRQ    <= 1'b0;
         IRQ_VECTOR <= 8'h00;
      end else begin
         REG_RDATA  <= nxt_rdata;
         AUX_IRQ    <= txf_ff | rxf_ff; // [R10]
         IRQ_VECTOR <= `SCFB_VECTOR;    // [R10]
      end
   end

   // Input synchronisers; a level counts once stages two and three agree.
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         miso_sy_ff  <= 3'b000;
         sck_sy_ff   <= 3'b000;
         miso_ff     <= 1'b0;
         sck_in_ff   <= 1'b0;
         sck_prev_ff <= 1'b0;
      end else begin
         miso_sy_ff  <= {miso_sy_ff[1:0], MISO};
         sck_sy_ff   <= {sck_sy_ff[1:0], SCK};
         if (miso_sy_ff[1] == miso_sy_ff[2]) begin
            miso_ff <= miso_sy_ff[2];
         end
         if (sck_sy_ff[1] == sck_sy_ff[2]) begin
            sck_in_ff <= sck_sy_ff[2];
         end
         sck_prev_ff <= sck_in_ff;
      end
   end

   // Shifter: mode 0, MSB first; samples on the sampled-back rising edge.
   // Sampling SCK back costs latency but keeps MOSI and MISO in step.
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         st_ff        <= ST_IDLE;
         div_ff       <= 4'h0;
         sh_ff        <= 8'h00;
         bit_ff       <= 3'h0;
         SCK          <= 1'b0;
         MOSI         <= 1'b0;
         byte_done_ff <= 1'b0;
         rx_byte_ff   <= 8'h00;
         f_pop        <= 1'b0;
      end else begin
         byte_done_ff <= 1'b0;
         f_pop        <= 1'b0;
         case (st_ff)
            ST_IDLE: begin
               // A stale head is popped without touching the wire.
               if (skip) begin
                  f_pop <= 1'b1; // [R1]
               end else if (f_valid && !f_pop) begin
                  sh_ff  <= f_out;
                  MOSI   <= f_out[7];
                  f_pop  <= 1'b1;
                  bit_ff <= 3'h0;
                  div_ff <= 4'h0;
                  st_ff  <= ST_SHFT;
               end
            end
            ST_SHFT: begin
               div_ff <= div_ff + 4'h1;
               if (div_ff == `SCFB_CLK_DIV) begin
                  div_ff <= 4'h0;
                  SCK    <= ~SCK;
               end
               if (sck_rise) begin
                  sh_ff <= {sh_ff[6:0], miso_ff};
               end
               if (sck_fall) begin
                  MOSI   <= sh_ff[7];
                  bit_ff <= bit_ff + 3'h1;
                  if (bit_ff == 3'h7) begin
                     st_ff <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               SCK          <= 1'b0;
               rx_byte_ff   <= sh_ff;
               byte_done_ff <= 1'b1; // [R7] [R15]
               st_ff        <= ST_IDLE;
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end
endmodule

// ===== test/scfb_top_props.sv
/*
   Checker for the circular-buffer serial port, bound to scfb_top.
   Assumes the register map of scfb_consts.vh and a single clock domain.
*/
`timescale 1ns/10ps
`include "scfb_consts.vh"
module scfb_top_props (
   input wire       SYS_CLK,
   input wire       RST,
   input wire [3:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire       REG_WR,
   input wire [7:0] REG_RDATA,
   input wire       AUX_IRQ,
   input wire [7:0] IRQ_VECTOR,
   input wire       SCK
);
   reg [7:0] last_start_ff;   // Last value written to the start register.

   // Remember the start value so the end-write revert can be judged.
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST)
         last_start_ff <= 8'h00;
      else if (REG_WR && REG_ADDR == `SCFB_ADDR_START)
         last_start_ff <= REG_WDATA;
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sequence s_start_wr;
      REG_WR && REG_ADDR == `SCFB_ADDR_START;
   endsequence
   sequence s_end_wr;
      REG_WR && REG_ADDR == `SCFB_ADDR_END;
   endsequence
   sequence s_flush(logic [3:0] a);
      REG_WR && REG_ADDR == a && REG_WDATA[7] ##1 REG_ADDR == a && !REG_WR;
   endsequence

   vector_fixed_a: assert property (!$past(RST) |-> IRQ_VECTOR == `SCFB_VECTOR)
      else $error("interrupt vector wrong");
   irq_from_flag_a: assert property (
      $past(REG_ADDR) == `SCFB_ADDR_PSTAT && !$past(RST) && |REG_RDATA[3:2] |-> ##[0:1] AUX_IRQ)
      else $error("flag set without interrupt");
   tx_flush_a: assert property (
      s_flush(`SCFB_ADDR_TCON) |=> (REG_RDATA & `SCFB_CNT_MASK) == 8'h00)
      else $error("transmit count not cleared by flush");
   rx_flush_a: assert property (
      s_flush(`SCFB_ADDR_RCON) |=> (REG_RDATA & `SCFB_CNT_MASK) == 8'h00)
      else $error("receive count not cleared by flush");
   start_copy_a: assert property (
      s_start_wr ##2 (REG_ADDR == `SCFB_ADDR_END && !REG_WR) |=> REG_RDATA == $past(REG_WDATA, 3))
      else $error("start write not copied to end pointer");
   end_revert_a: assert property (
      s_end_wr ##1 (REG_ADDR == `SCFB_ADDR_END && !REG_WR) |=> REG_RDATA == last_start_ff)
      else $error("end pointer did not revert to start");
   unmapped_zero_a: assert property (REG_ADDR > `SCFB_ADDR_CTRL |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   sck_half_a: assert property ($rose(SCK) |-> SCK [*8] ##1 !SCK)
      else $error("serial clock high phase wrong");
endmodule
bind scfb_top scfb_top_props scfb_top_props_i (.SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .AUX_IRQ(AUX_IRQ),
   .IRQ_VECTOR(IRQ_VECTOR), .SCK(SCK));

// ===== test/scfb_slave_model.sv
/*
   Behavioural serial slave: captures MOSI on the rising serial clock edge,
   presents MISO, MSB first, after the falling edge.
   Assumes the master keeps the clock low between bytes.
*/
`timescale 1ns/10ps
module scfb_slave_model (
   input  wire sck,
   input  wire mosi,
   output reg  miso
);
   reg [7:0] got_q[$];    // Bytes seen from the master.
   reg [7:0] sent_q[$];   // Bytes handed back to the master.
   reg [7:0] cur_ff;      // Byte now being returned.
   reg [7:0] sh_ff;       // Outgoing shift register.
   reg [7:0] rx_ff;       // Incoming shift register.
   integer   bits;        // Bits done in this byte.

   initial begin
      cur_ff = 8'hC3;
      sh_ff = 8'hC3;
      rx_ff = 8'h00;
      bits = 0;
      miso = sh_ff[7];
   end

   // Sample on the rising edge; a new pattern each byte catches stale data.
   always @(posedge sck) begin
      rx_ff = {rx_ff[6:0], mosi};
      bits = bits + 1;
      if (bits == 8) begin
         got_q.push_back(rx_ff);
         sent_q.push_back(cur_ff);
         cur_ff = cur_ff + 8'h3B;
         bits = 0;
      end
   end

   // Shift on the falling edge so the line is settled before sampling.
   always @(negedge sck) begin
      if (bits == 0)
         sh_ff = cur_ff;
      else
         sh_ff = {sh_ff[6:0], ~sh_ff[6]};
      miso = sh_ff[7];
   end
endmodule

// ===== test/scfb_top_bench.sv
/*
   Self-checking bench for scfb_top with a serial slave model.
   Assumes the register map of scfb_consts.vh; inputs change on falling edges.
*/
`timescale 1ns/10ps
`include "scfb_consts.vh"
module scfb_top_bench;
   reg        sys_clk = 1'b0;       // 10 MHz system clock.
   reg        rst = 1'b1;           // Held for three cycles.
   reg  [3:0] reg_addr = 4'h0;
   reg  [7:0] reg_wdata = 8'h00;
   reg        reg_wr = 1'b0;
   reg        reg_rd = 1'b0;
   wire [7:0] reg_rdata, irq_vector;
   wire       aux_irq, sck, mosi, miso;
   integer    bad_count = 0, num_checks = 0, i;
   reg [31:0] seed = 32'h943D;      // Fixed seed keeps runs repeatable.
   reg [7:0]  v, d, ep;             // Random byte, read data, expected pointer.
   reg [7:0]  wq[$];                // Bytes queued for transmission.

   always #50 sys_clk = ~sys_clk;

   scfb_top scfb_top_i (.SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .AUX_IRQ(aux_irq), .IRQ_VECTOR(irq_vector), .SCK(sck), .MOSI(mosi), .MISO(miso));
   scfb_slave_model slave_i (.sck(sck), .mosi(mosi), .miso(miso));

   // Next random byte from a 32-bit shift register.
   function [7:0] nxt_rnd();
      begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
         nxt_rnd = seed[7:0] ^ seed[15:8];
      end
   endfunction

   // Expected pointer step inside a ring of lo..hi, wrapping past hi.
   function [7:0] exp_step(input [7:0] p, input [7:0] lo, input [7:0] hi);
      exp_step = (p >= hi) ? lo : p + 8'h01;
   endfunction

   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("FAIL %s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   // One-cycle write strobe.
   task wr(input [3:0] a, input [7:0] x);
      begin
         @(negedge sys_clk) {reg_addr, reg_wdata, reg_wr} = {a, x, 1'b1};
         @(negedge sys_clk) reg_wr = 1'b0;
      end
   endtask

   // Read data lags the address by a cycle, so the pop follows the capture.
   task rd(input [3:0] a, input pop, output [7:0] x);
      begin
         @(negedge sys_clk) reg_addr = a;
         @(negedge sys_clk) x = reg_rdata;
         reg_rd = pop;
         @(negedge sys_clk) reg_rd = 1'b0;
      end
   endtask

   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", num_checks, bad_count);
         if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   // Poll the transmit count, bounded; a hang ends the run.
   task send(input integer n);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            v = nxt_rnd();
            wq.push_back(v);
            wr(`SCFB_ADDR_DATA, v);
         end
         d = 8'h7F;
         for (k = 0; k < 500 && (d & 8'h7F) != 8'h00; k = k + 1)
            rd(`SCFB_ADDR_TCON, 1'b0, d);
         chk("tx_drain", 8'h00, d & 8'h7F);
         if ((d & 8'h7F) != 8'h00)
            tally_and_finish;
         repeat (40) @(negedge sys_clk);
      end
   endtask

   initial begin
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      chk("vector", `SCFB_VECTOR, irq_vector);
      chk("irq_idle", 8'h00, {7'h00, aux_irq});
      wr(`SCFB_ADDR_START, 8'hA0);
      rd(`SCFB_ADDR_END, 1'b0, d);
      chk("end_ptr", 8'hA0, d);
      wr(`SCFB_ADDR_END, 8'hB0);
      rd(`SCFB_ADDR_END, 1'b0, d);
      chk("end_revert", 8'hA0, d);
      rd(4'hC, 1'b0, d);
      chk("unmapped", 8'h00, d);
      wr(`SCFB_ADDR_TTHR, 8'h04);
      wr(`SCFB_ADDR_RTHR, 8'h02);
      rd(`SCFB_ADDR_PSTAT, 1'b0, d);
      chk("tx_flag", 8'h08, d & 8'h0C);
      chk("irq_on", 8'h01, {7'h00, aux_irq});
      // Link still disabled, so these bytes stay queued.
      for (i = 0; i < 5; i = i + 1) begin
         v = nxt_rnd();
         wr(`SCFB_ADDR_DATA, v);
      end
      rd(`SCFB_ADDR_TCON, 1'b0, d);
      chk("tx_count", 8'h05, d & 8'h7F);
      rd(`SCFB_ADDR_START, 1'b0, d);
      chk("tx_ptr", 8'hA5, d);
      wr(`SCFB_ADDR_PSTAT, 8'h00);
      rd(`SCFB_ADDR_PSTAT, 1'b0, d);
      chk("flag_clear", 8'h00, d & 8'h0C);
      chk("irq_off", 8'h00, {7'h00, aux_irq});
      wr(`SCFB_ADDR_TCON, 8'h80);
      rd(`SCFB_ADDR_START, 1'b0, d);
      chk("flush_ptr", 8'hA0, d);
      rd(`SCFB_ADDR_TTHR, 1'b0, d);
      chk("tthr_kept", 8'h04, d);
      rd(`SCFB_ADDR_PSTAT, 1'b0, d);
      chk("tx_reflag", 8'h08, d & 8'h08);
      // Live traffic: three bytes out, three back.
      wr(`SCFB_ADDR_CTRL, 8'h01);
      send(3);
      for (i = 0; i < 3; i = i + 1)
         chk("mosi_byte", wq[i], slave_i.got_q[i]);
      rd(`SCFB_ADDR_RCON, 1'b0, d);
      chk("rx_count", 8'h03, d & 8'h7F);
      rd(`SCFB_ADDR_PSTAT, 1'b0, d);
      chk("rx_flag", 8'h04, d & 8'h04);
      for (i = 0; i < 3; i = i + 1) begin
         rd(`SCFB_ADDR_DATA, 1'b1, d);
         chk("rx_byte", slave_i.sent_q[i], d);
      end
      rd(`SCFB_ADDR_RCON, 1'b0, d);
      chk("rx_empty", 8'h00, d & 8'h7F);
      wr(`SCFB_ADDR_TTHR, 8'h00);
      wr(`SCFB_ADDR_RTHR, 8'h7F);
      wr(`SCFB_ADDR_PSTAT, 8'h00);
      send(2);
      rd(`SCFB_ADDR_PSTAT, 1'b0, d);
      chk("no_flags", 8'h00, d & 8'h0C);
      chk("irq_quiet", 8'h00, {7'h00, aux_irq});
      rd(`SCFB_ADDR_RCON, 1'b0, d);
      chk("rx_two", 8'h02, d & 8'h7F);
      wr(`SCFB_ADDR_RCON, 8'h80);
      rd(`SCFB_ADDR_RCON, 1'b0, d);
      chk("rx_flush", 8'h00, d & 8'h7F);
      rd(`SCFB_ADDR_END, 1'b0, d);
      chk("rx_flush_ptr", 8'hA5, d);
      rd(`SCFB_ADDR_RTHR, 1'b0, d);
      chk("rthr_kept", 8'h7F, d);
      // A three-byte ring must keep the pointer inside its bounds.
      wr(`SCFB_ADDR_CTRL, 8'h00);
      wr(`SCFB_ADDR_START, 8'hA0);
      wr(`SCFB_ADDR_END, 8'hA2);
      ep = 8'hA0;
      for (i = 0; i < 4; i = i + 1) begin
         v = nxt_rnd();
         wr(`SCFB_ADDR_DATA, v);
         ep = exp_step(ep, 8'hA0, 8'hA2);
         rd(`SCFB_ADDR_START, 1'b0, d);
         chk("wrap_ptr", ep, d);
      end
      tally_and_finish;
   end
endmodule
